// File: core/gtp_pkg.sv
// Purpose: shared constants and types of the general timer block
// Assumes: 32-bit APB register access, one aligned word per register
// Notes: control word layout is carried by gtp_ctrl_s
package gtp_pkg;
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [11:0] OFS_RELOAD = 12'h320;
   localparam logic [11:0] OFS_COUNT = 12'h324;
   localparam logic [11:0] OFS_CTRL = 12'h328;
   localparam logic [11:0] OFS_IRQ_CLEAR = 12'h32c;
   localparam logic [11:0] OFS_CAPTURE = 12'h330;
   localparam logic [11:0] OFS_INT_STATUS = 12'h334;
   localparam logic [11:0] OFS_INT_ENABLE = 12'h338;
   localparam logic [11:0] OFS_INT_CLEAR = 12'h33c;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [31:0] RST_CTRL = 32'h01000000;
   localparam logic [31:0] RST_COUNT = 32'hffffffff;
   localparam logic [31:0] RST_CAPTURE = 32'h00000000;
   localparam logic [31:0] RST_RELOAD = 32'h00000000;
   localparam logic [2:0] RST_INT_ENABLE = 3'h1;

   // ---------------------------------------------------------------
   // field encodings
   // ---------------------------------------------------------------
   localparam logic [2:0] CLK_CORE = 3'h0;
   localparam logic [2:0] CLK_LOWPOWER = 3'h1;
   localparam logic [2:0] CLK_PIN_A = 3'h2;
   localparam logic [2:0] CLK_PIN_B = 3'h3;
   localparam logic [1:0] FMT_HMS_23 = 2'h2;
   localparam logic [1:0] FMT_HMS_255 = 2'h3;
   localparam logic [3:0] PRE_DIV16 = 4'h4;
   localparam logic [3:0] PRE_DIV256 = 4'h8;
   localparam logic [3:0] PRE_DIV32768 = 4'hf;
   localparam logic [14:0] LIM_DIV1 = 15'h0000;
   localparam logic [14:0] LIM_DIV16 = 15'h000f;
   localparam logic [14:0] LIM_DIV256 = 15'h00ff;
   localparam logic [14:0] LIM_DIV32768 = 15'h7fff;
   localparam logic [7:0] POST_ONE = 8'h01;
   localparam logic [7:0] HUND_MAX = 8'h63;
   localparam logic [7:0] MINSEC_MAX = 8'h3b;
   localparam logic [7:0] HOUR_MAX_23 = 8'h17;
   localparam logic [7:0] HOUR_MAX_255 = 8'hff;

   // ---------------------------------------------------------------
   // interrupt status bit positions
   // ---------------------------------------------------------------
   localparam int IRQ_TIMER = 0;
   localparam int IRQ_POST_MATCH = 1;
   localparam int IRQ_CAPTURE = 2;
   localparam int IRQ_W = 3;

   typedef struct packed {
      logic [7:0] post;
      logic post_en;
      logic [2:0] rsv;
      logic cmp_flag;
      logic irq_sel;
      logic cap_en;
      logic [4:0] evt_sel;
      logic [2:0] clk_sel;
      logic up;
      logic en;
      logic periodic;
      logic [1:0] fmt;
      logic [3:0] presc;
   } gtp_ctrl_s;
endpackage

// File: core/gtp_sync_rise.sv
// Purpose: two-flop synchroniser with rising-edge pulse per bit
// Assumes: inputs asynchronous to clk
// Notes: pulse is one clk cycle, in the same cycle the second flop goes high
`timescale 1ns/1ns
module gtp_sync_rise #(
   parameter int W = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // async levels in, rise pulses out
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] rise
);
   logic [W-1:0] meta;
   logic [W-1:0] sync;
   logic [W-1:0] last;

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         meta <= '0;
         sync <= '0;
         last <= '0;
      end
      else
      begin
         meta <= async_in;
         sync <= meta;
         last <= sync;
      end
   end

   // edge taken from the second flop and its delayed copy, never the metastable one
   assign rise = sync & ~last;
endmodule

// File: core/gtp_timer.sv
// Purpose: 32-bit general timer with prescaler, postscaler and capture
// Assumes: APB slave, zero wait states, irq_src on clk domain
// Notes: low-power clock and pins are sampled, count on rising edges
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ns
module gtp_timer (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // count sources from outside the clock domain
   input wire logic lowpower_clk,
   input wire logic pin_a,
   input wire logic pin_b,
   // capture event sources
   input wire logic [31:0] irq_src,
   // interrupt
   output logic irq
);
   gtp_pkg::gtp_ctrl_s ctrl;
   logic [31:0] reload;
   logic [31:0] count;
   logic [31:0] capture;
   logic [7:0] post_term;
   logic [7:0] post_cnt;
   logic [14:0] presc_cnt;
   logic [2:0] src_rise;
   logic [31:0] irq_src_q;
   logic [gtp_pkg::IRQ_W-1:0] int_status;
   logic [gtp_pkg::IRQ_W-1:0] int_enable;
   logic src_tick;
   logic tick;
   logic at_end;
   logic timeout;
   logic post_match;
   logic irq_event;
   logic cap_hit;
   logic [31:0] next_count;
   logic [7:0] hour_max;
   logic wr;
   logic rd_setup;

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   function automatic logic is_wr(input logic [11:0] ofs);
      is_wr = wr && (paddr == ofs);
   endfunction

   function automatic logic [14:0] presc_limit(input logic [3:0] code);
      case (code)
         gtp_pkg::PRE_DIV16: presc_limit = gtp_pkg::LIM_DIV16;
         gtp_pkg::PRE_DIV256: presc_limit = gtp_pkg::LIM_DIV256;
         gtp_pkg::PRE_DIV32768: presc_limit = gtp_pkg::LIM_DIV32768;
         default: presc_limit = gtp_pkg::LIM_DIV1;
      endcase
   endfunction

   // one h:m:s:hundredths step, each field a binary byte
   function automatic logic [31:0] hms_step(input logic [31:0] v,
      input logic up, input logic [7:0] hmax);
      logic [7:0] f [4];
      logic [7:0] lim [4];
      logic carry;
      f[0] = v[7:0];
      f[1] = v[15:8];
      f[2] = v[23:16];
      f[3] = v[31:24];
      lim[0] = gtp_pkg::HUND_MAX;
      lim[1] = gtp_pkg::MINSEC_MAX;
      lim[2] = gtp_pkg::MINSEC_MAX;
      lim[3] = hmax;
      carry = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         if (carry)
         begin
            if (up)
            begin
               carry = (f[i] >= lim[i]);
               f[i] = carry ? 8'h00 : f[i] + 8'h01;
            end
            else
            begin
               carry = (f[i] == 8'h00);
               f[i] = carry ? lim[i] : f[i] - 8'h01;
            end
         end
      end
      hms_step = {f[3], f[2], f[1], f[0]};
   endfunction

   assign wr = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // ---------------------------------------------------------------
   // source selection and prescaler
   // ---------------------------------------------------------------
   gtp_sync_rise #(
      .W(3)
   ) u_sync (
      .clk(clk),
      .resetn(resetn),
      .async_in({pin_b, pin_a, lowpower_clk}),
      .rise(src_rise)
   );

   always_comb
   begin
      case (ctrl.clk_sel)
         gtp_pkg::CLK_CORE: src_tick = 1'b1;
         gtp_pkg::CLK_LOWPOWER: src_tick = src_rise[0];
         gtp_pkg::CLK_PIN_A: src_tick = src_rise[1];
         gtp_pkg::CLK_PIN_B: src_tick = src_rise[2];
         default: src_tick = 1'b0;
      endcase
   end

   assign tick = ctrl.en && src_tick &&
      (presc_cnt >= presc_limit(ctrl.presc));

   always_ff @(posedge clk)
   begin
      if (!resetn)
         presc_cnt <= '0;
      else if (!ctrl.en || tick)
         presc_cnt <= '0;
      else if (src_tick)
         presc_cnt <= presc_cnt + 15'h0001;
   end

   // ---------------------------------------------------------------
   // main counter
   // ---------------------------------------------------------------
   assign hour_max = (ctrl.fmt == gtp_pkg::FMT_HMS_255) ?
      gtp_pkg::HOUR_MAX_255 : gtp_pkg::HOUR_MAX_23;

   always_comb
   begin
      next_count = count;
      at_end = 1'b0;
      if (ctrl.fmt == gtp_pkg::FMT_HMS_23 ||
         ctrl.fmt == gtp_pkg::FMT_HMS_255)
      begin
         at_end = ctrl.up ? (count == {hour_max, gtp_pkg::MINSEC_MAX,
            gtp_pkg::MINSEC_MAX, gtp_pkg::HUND_MAX}) : (count == '0);
         next_count = hms_step(count, ctrl.up, hour_max);
      end
      else
      begin
         at_end = ctrl.up ? (count == '1) : (count == '0);
         next_count = ctrl.up ? count + 32'h1 : count - 32'h1;
      end
      if (at_end && ctrl.periodic)
         next_count = reload;
   end

   assign timeout = tick && at_end;

   always_ff @(posedge clk)
   begin
      if (!resetn)
         count <= gtp_pkg::RST_COUNT;
      else if (tick)
         count <= next_count;
   end

   // ---------------------------------------------------------------
   // postscaler
   // ---------------------------------------------------------------
   assign post_match = ctrl.post_en && timeout &&
      (post_cnt + 8'h01 == post_term);

   always_ff @(posedge clk)
   begin
      if (!resetn)
         post_cnt <= '0;
      else if (!ctrl.post_en || post_match)
         post_cnt <= '0;
      else if (timeout)
         post_cnt <= post_cnt + 8'h01;
   end

   localparam logic [7:0] POST_RST = gtp_pkg::RST_CTRL[31:24];

   always_ff @(posedge clk)
   begin
      if (!resetn)
         post_term <= POST_RST;
      else if (is_wr(gtp_pkg::OFS_CTRL))
         post_term <= (pwdata[31:24] == 8'h00) ?
            gtp_pkg::POST_ONE : pwdata[31:24];
   end

   // interrupt origin choice
   assign irq_event = ctrl.irq_sel ? post_match : timeout;

   // ---------------------------------------------------------------
   // control, reload and capture registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         ctrl <= gtp_pkg::RST_CTRL;
         reload <= gtp_pkg::RST_RELOAD;
      end
      else
      begin
         if (is_wr(gtp_pkg::OFS_CTRL))
         begin
            ctrl <= pwdata;
            ctrl.post <= '0;
            ctrl.rsv <= '0;
         end
         if (is_wr(gtp_pkg::OFS_RELOAD))
            reload <= pwdata;
         // set beats clear; software can only clear the flag, by a write to OFS_IRQ_CLEAR
         if (post_match)
            ctrl.cmp_flag <= 1'b1;
         else if (is_wr(gtp_pkg::OFS_IRQ_CLEAR))
            ctrl.cmp_flag <= 1'b0;
         else if (is_wr(gtp_pkg::OFS_CTRL))
            ctrl.cmp_flag <= ctrl.cmp_flag;
      end
   end

   assign cap_hit = ctrl.cap_en && irq_src[ctrl.evt_sel] &&
      !irq_src_q[ctrl.evt_sel];

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         irq_src_q <= '0;
         capture <= gtp_pkg::RST_CAPTURE;
      end
      else
      begin
         irq_src_q <= irq_src;
         if (cap_hit)
            capture <= count;
      end
   end

   // ---------------------------------------------------------------
   // interrupt status, enable and output
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         int_status <= '0;
         int_enable <= gtp_pkg::RST_INT_ENABLE;
      end
      else
      begin
         if (is_wr(gtp_pkg::OFS_INT_ENABLE))
            int_enable <= pwdata[gtp_pkg::IRQ_W-1:0];
         int_status <= (int_status
            & ~(is_wr(gtp_pkg::OFS_INT_CLEAR) ?
               pwdata[gtp_pkg::IRQ_W-1:0] : '0)
            & ~{2'b00, is_wr(gtp_pkg::OFS_IRQ_CLEAR)})
            | {cap_hit, post_match, irq_event};
      end
   end

   assign irq = |(int_status & int_enable);

   // ---------------------------------------------------------------
   // read data, taken in the setup cycle
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!resetn)
         prdata <= '0;
      else if (rd_setup)
      begin
         case (paddr)
            gtp_pkg::OFS_RELOAD: prdata <= reload;
            gtp_pkg::OFS_COUNT: prdata <= count;
            gtp_pkg::OFS_CTRL: prdata <= {post_cnt, ctrl[23:0]};
            gtp_pkg::OFS_CAPTURE: prdata <= capture;
            gtp_pkg::OFS_INT_STATUS: prdata <= {29'h0, int_status};
            gtp_pkg::OFS_INT_ENABLE: prdata <= {29'h0, int_enable};
            default: prdata <= '0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_ctrl_write;
      psel && penable && pwrite && paddr == gtp_pkg::OFS_CTRL;
   endsequence

   sequence s_clr_write;
      psel && penable && pwrite && paddr == gtp_pkg::OFS_IRQ_CLEAR;
   endsequence

   property p_zero_as_one;
      s_ctrl_write and (pwdata[31:24] == 8'h00) |=>
         post_term == gtp_pkg::POST_ONE;
   endproperty
   a_zero_as_one: assert property (p_zero_as_one)
      else $error("zero postscaler not taken as one");

   property p_live_read;
      psel && !penable && !pwrite && paddr == gtp_pkg::OFS_CTRL |=>
         prdata[31:24] == $past(post_cnt);
   endproperty
   a_live_read: assert property (p_live_read)
      else $error("control read lacks live postscaler count");

   // a plain timeout must not raise the timer bit when matches are chosen
   property p_irq_origin;
      ctrl.irq_sel && timeout && !post_match &&
         !int_status[gtp_pkg::IRQ_TIMER] |=> !int_status[gtp_pkg::IRQ_TIMER];
   endproperty
   a_irq_origin: assert property (p_irq_origin)
      else $error("interrupt raised from wrong origin");

   property p_post_count;
      ctrl.post_en && ctrl.irq_sel && irq_event |->
         post_cnt == post_term - 8'h01;
   endproperty
   a_post_count: assert property (p_post_count)
      else $error("postscaler interrupt at wrong period");

   property p_flag_set;
      post_match |=> ctrl.cmp_flag ##0 int_status[gtp_pkg::IRQ_POST_MATCH];
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("compare flag not set on match");

   property p_flag_ro;
      s_ctrl_write and ctrl.cmp_flag |=> ctrl.cmp_flag;
   endproperty
   a_flag_ro: assert property (p_flag_ro)
      else $error("software write altered compare flag");

   property p_capture_gate;
      !ctrl.cap_en |=> capture == $past(capture);
   endproperty
   a_capture_gate: assert property (p_capture_gate)
      else $error("capture while disabled");

   property p_hold;
      !ctrl.en |=> count == $past(count);
   endproperty
   a_hold: assert property (p_hold)
      else $error("counter moved while disabled");

   property p_reload;
      timeout && ctrl.periodic |=> count == $past(reload);
   endproperty
   a_reload: assert property (p_reload)
      else $error("no reload on overflow");

   property p_post_restart;
      post_match |=> post_cnt == 8'h00 [*1] ##0 ctrl.cmp_flag;
   endproperty
   a_post_restart: assert property (p_post_restart)
      else $error("postscaler did not restart");

   property p_clear;
      s_clr_write and !irq_event |=> !int_status[gtp_pkg::IRQ_TIMER];
   endproperty
   a_clear: assert property (p_clear)
      else $error("interrupt clear write ignored");
endmodule

// File: dv/gtp_timer_tb.sv
// Purpose: self-checking bench for the general timer over apb
// Assumes: zero-wait apb slave, pins driven slowly enough to sync
// Notes: pin-clocked counts are steered with single pin edges so values are exact
`timescale 1ns/1ns
`define CHK(nm, ex, gt) \
   begin \
      cmp_count++; \
      if ((gt) !== (ex)) \
      begin \
         error_cnt++; \
         $display("ERROR %s exp %h got %h", nm, ex, gt); \
      end \
   end
module gtp_timer_tb;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic lowpower_clk = 1'b0;
   logic pin_a = 1'b0;
   logic pin_b = 1'b0;
   logic [31:0] irq_src = 32'h00000000;
   logic irq;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [31:0] v, c0, c1, cap;
   int g, t;
   // ---------------------------------------------------------------
   // step tables
   // ---------------------------------------------------------------
   // ctrl word, pin pulsed (0 lowpower, 1 pin_a, 2 pin_b), count after
   localparam logic [31:0] FT_CTRL [0:11] = '{32'h580, 32'h4a0, 32'h4a0,
      32'h5a0, 32'h5a0, 32'h4b0, 32'h5b0, 32'h490, 32'h580, 32'h780,
      32'h380, 32'h380};
   localparam int FT_PIN [0:11] = '{1, 1, 1, 1, 1, 1, 1, 1, 2, 2, 0, 1};
   // steps 8 and 11 pulse a pin that is not selected: no count
   localparam logic [31:0] FT_EXP [0:11] = '{32'h0, 32'h173b3b63,
      32'h173b3b62, 32'h173b3b63, 32'h0, 32'hff3b3b63, 32'h0,
      32'hffffffff, 32'hffffffff, 32'h0, 32'h1, 32'h1};
   localparam logic [3:0] PS_CODE [0:4] = '{4'h0, 4'h4, 4'h8, 4'h1, 4'hf};
   localparam int PS_GAP [0:4] = '{40, 320, 2560, 40, 32768};
   localparam logic [31:0] PS_DELTA [0:4] = '{32'd40, 32'd20, 32'd10,
      32'd40, 32'd1};
   localparam logic [31:0] PO_CTRL [0:2] = '{32'h008400c0, 32'h038000c0,
      32'h038400c0};
   localparam int PO_GAP [0:2] = '{16, 16, 48};
   localparam logic [11:0] RS_ADDR [0:6] = '{gtp_pkg::OFS_RELOAD,
      gtp_pkg::OFS_COUNT, gtp_pkg::OFS_CTRL, gtp_pkg::OFS_CAPTURE,
      gtp_pkg::OFS_INT_STATUS, gtp_pkg::OFS_INT_ENABLE, 12'h100};
   // control top byte reads the live postscaler count, zero after reset
   localparam logic [31:0] RS_VAL [0:6] = '{gtp_pkg::RST_RELOAD,
      gtp_pkg::RST_COUNT, gtp_pkg::RST_CTRL & 32'h00ffffff,
      gtp_pkg::RST_CAPTURE, 32'h0, 32'h1, 32'h0};

   gtp_timer DUT (
      .clk(clk),
      .resetn(resetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .lowpower_clk(lowpower_clk),
      .pin_a(pin_a),
      .pin_b(pin_b),
      .irq_src(irq_src),
      .irq(irq)
   );

   always #5 clk = ~clk;

   // ---------------------------------------------------------------
   // bus and pin tasks
   // ---------------------------------------------------------------
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
      begin
         @(posedge clk);
      end
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      apb(1'b1, a, d, dummy);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] r);
      apb(1'b0, a, 32'h0, r);
   endtask

   // slow pulse so the synchroniser sees exactly one rising edge
   task automatic pulse(input int which);
      @(posedge clk);
      case (which)
         0: lowpower_clk <= 1'b1;
         1: pin_a <= 1'b1;
         default: pin_b <= 1'b1;
      endcase
      repeat (3) @(posedge clk);
      lowpower_clk <= 1'b0;
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      repeat (6) @(posedge clk);
   endtask

   task automatic wait_irq(output int tm);
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end
      while (irq !== 1'b1 && n < 500);
      `CHK("irq_rise", 1'b1, irq)
      tm = cyc;
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // hang guard, well above the longest prescaler run
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 80000)
      begin
         error_cnt++;
         conclude();
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      for (int i = 0; i < 7; i++)
      begin
         rd(RS_ADDR[i], v);
         `CHK("reset_value", RS_VAL[i], v)
      end
      `CHK("pslverr", 1'b0, pslverr)
      `CHK("irq_idle", 1'b0, irq)
      for (int i = 0; i < 12; i++)
      begin
         wr(gtp_pkg::OFS_CTRL, FT_CTRL[i]);
         pulse(FT_PIN[i]);
         rd(gtp_pkg::OFS_COUNT, v);
         `CHK("pin_count", FT_EXP[i], v)
      end
      // postscaler interval against plain timeout interval
      wr(gtp_pkg::OFS_RELOAD, 32'hf);
      rd(gtp_pkg::OFS_RELOAD, v);
      `CHK("reload", 32'hf, v)
      for (int i = 0; i < 3; i++)
      begin
         wr(gtp_pkg::OFS_CTRL, PO_CTRL[i]);
         wr(gtp_pkg::OFS_IRQ_CLEAR, 32'h0);
         wait_irq(t);
         wr(gtp_pkg::OFS_IRQ_CLEAR, 32'h5a);
         wait_irq(g);
         `CHK("irq_gap", PO_GAP[i], g - t)
      end
      rd(gtp_pkg::OFS_CTRL, v);
      `CHK("cmp_flag", 1'b1, v[19])
      `CHK("live_post", 8'h00, v[31:24])
      `CHK("rsv_bits", 3'h0, v[22:20])
      wr(gtp_pkg::OFS_IRQ_CLEAR, 32'h0);
      #1;
      `CHK("irq_cleared", 1'b0, irq)
      wr(gtp_pkg::OFS_CTRL, 32'h00080000);
      rd(gtp_pkg::OFS_CTRL, v);
      `CHK("flag_ro", 1'b0, v[19])
      // capture gating and source selection
      wr(gtp_pkg::OFS_CTRL, 32'h0001f180);
      irq_src <= 32'h80000000;
      repeat (3) @(posedge clk);
      irq_src <= 32'h0;
      rd(gtp_pkg::OFS_CAPTURE, v);
      `CHK("cap_off", 32'h0, v)
      wr(gtp_pkg::OFS_CTRL, 32'h0003f180);
      irq_src <= 32'h40000000;
      repeat (3) @(posedge clk);
      irq_src <= 32'h0;
      rd(gtp_pkg::OFS_CAPTURE, v);
      `CHK("cap_other_src", 32'h0, v)
      rd(gtp_pkg::OFS_COUNT, c0);
      irq_src <= 32'h80000000;
      repeat (3) @(posedge clk);
      rd(gtp_pkg::OFS_CAPTURE, cap);
      rd(gtp_pkg::OFS_COUNT, c1);
      `CHK("cap_window", 1'b1, (cap > c0) && (cap < c1))
      repeat (5) @(posedge clk);
      rd(gtp_pkg::OFS_CAPTURE, v);
      `CHK("cap_once", cap, v)
      irq_src <= 32'h0;
      rd(gtp_pkg::OFS_INT_STATUS, v);
      `CHK("cap_status", 1'b1, v[gtp_pkg::IRQ_CAPTURE])
      wr(gtp_pkg::OFS_INT_ENABLE, 32'h4);
      #1;
      `CHK("irq_enabled", 1'b1, irq)
      wr(gtp_pkg::OFS_INT_ENABLE, 32'h0);
      #1;
      `CHK("irq_masked", 1'b0, irq)
      wr(gtp_pkg::OFS_INT_ENABLE, 32'h4);
      wr(gtp_pkg::OFS_INT_CLEAR, 32'h4);
      #1;
      `CHK("irq_w1c", 1'b0, irq)
      rd(gtp_pkg::OFS_INT_STATUS, v);
      `CHK("status_w1c", 1'b0, v[gtp_pkg::IRQ_CAPTURE])
      // latch points of two reads lie gap cycles apart
      for (int i = 0; i < 5; i++)
      begin
         wr(gtp_pkg::OFS_CTRL, {28'h0000018, PS_CODE[i]});
         rd(gtp_pkg::OFS_COUNT, c0);
         repeat (PS_GAP[i] - 3) @(posedge clk);
         rd(gtp_pkg::OFS_COUNT, c1);
         `CHK("presc_delta", PS_DELTA[i], c1 - c0)
      end
      wr(gtp_pkg::OFS_CTRL, 32'h0);
      rd(gtp_pkg::OFS_COUNT, c0);
      repeat (20) @(posedge clk);
      rd(gtp_pkg::OFS_COUNT, c1);
      `CHK("stopped", c0, c1)
      conclude();
   end
endmodule
